//--- rtl/peis_pkg.sv
// Function
// - flag bit 15 set on link quality change while link is up.
// - flag bit 14 set on any change of line energy detection.
// - flag bit 13 set on any change of link up/down status.
// - flag bit 12 set on any change of resolved speed.
// - flag bit 11 set on any change of duplex status.
// - flag bit 10 set when auto-negotiation completes.
// - flag bit 9 set when false carrier counter (0x14) passes half range.
// - flag bit 8 set when receive error counter (0x15) passes half range.
// - enable bit 7 gates the link quality flag onto the interrupt.
// - enable bit 6 gates the energy detection flag onto the interrupt.
// - enable bit 5 gates the link status flag onto the interrupt.
// - enable bit 4 gates the speed change flag onto the interrupt.
// - enable bit 3 gates the duplex change flag onto the interrupt.
// - enable bit 2 gates the auto-negotiation flag onto the interrupt.
// - enable bit 1 gates the false carrier half-full flag.
// - enable bit 0 gates the receive error half-full flag.
// - register sits at management offset 0x12, all bits reset to zero.
// - event interrupts need the global enable in the control register.
// - shared pin is interrupt output only when output enable is 1.
// - polarity 1 idles pin high, asserts low; polarity 0 the reverse.
// - 8-bit counter saturates, events once above 7Fh, clears on read.
package peis_pkg;
  // -------------------------------------------------------------
  // management register map
  // -------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] REG_IRQ_CTRL = 5'h11;
  localparam logic [4:0] REG_EVT_ONE = 5'h12;
  localparam logic [4:0] REG_EVT_TWO = 5'h13;
  localparam logic [4:0] REG_FC_CNT = 5'h14;
  localparam logic [4:0] REG_RXE_CNT = 5'h15;
  // -------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------
  localparam int NUM_EVT = 8;
  localparam int FLAG_LSB = 8;
  localparam int EVT_LQ = 7;
  localparam int EVT_ENERGY = 6;
  localparam int EVT_LINK = 5;
  localparam int EVT_SPEED = 4;
  localparam int EVT_DUPLEX = 3;
  localparam int EVT_ANEG = 2;
  localparam int EVT_FC_HALF = 1;
  localparam int EVT_RXE_HALF = 0;
  localparam int CTL_POL = 3;
  localparam int CTL_TEST = 2;
  localparam int CTL_GIE = 1;
  localparam int CTL_OE = 0;
  localparam logic [3:0] CTL_RESET = 4'h8;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  // -------------------------------------------------------------
  // counters
  // -------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_HALF = 8'h7F;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // -------------------------------------------------------------
  // management frame
  // -------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0C;
  localparam logic [4:0] RD_BITS = 5'h10;
  localparam logic [4:0] WR_BITS = 5'h12;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HDR = 5'b00010,
    ST_RTA = 5'b00100,
    ST_RD = 5'b01000,
    ST_WR = 5'b10000
  } peis_state_e;
endpackage : peis_pkg

//--- rtl/peis_sync.sv
`timescale 1ns/100ps
`default_nettype none
module peis_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // pin levels
  output var logic [WIDTH-1:0] sync_out // levels in core domain
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // idle levels, so no false edge or level shows after release
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : peis_sync
`default_nettype wire

//--- rtl/peis_counter.sv
`timescale 1ns/100ps
`default_nettype none
module peis_counter
  import peis_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic event_in, // one-cycle event pulse
  input wire logic clear, // clear-on-read pulse
  output var logic [peis_pkg::CNT_W-1:0] count, // current count
  output var logic half_evt // pulse on passing half range
);
  // an event in the clearing cycle counts as the first of the new run
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (clear) begin
      count <= event_in ? CNT_W'(1) : '0;
    end else if (event_in && count != CNT_MAX) begin
      count <= count + CNT_W'(1);
    end
  end

  // fires once per run: crossing 7Fh happens only once until cleared
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      half_evt <= 1'b0;
    end else begin
      half_evt <= event_in && !clear && count == CNT_HALF;
    end
  end
endmodule : peis_counter
`default_nettype wire

//--- rtl/peis_top.sv
`timescale 1ns/100ps
`default_nettype none
module peis_top
  import peis_pkg::*;
#(
  parameter logic [peis_pkg::ADDR_W-1:0] PHY_ADDR = 5'h00
) (
  input wire logic core_clk, // system clock, 20 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic mdc, // management clock pin
  input wire logic mdio_in, // management data, pin level
  output var logic mdio_out, // management data driven value
  output var logic mdio_oe, // management data drive enable
  input wire logic irq_pin_in, // shared pin level
  output var logic irq_pin_out, // shared pin driven value
  output var logic irq_pin_oe, // shared pin drive enable
  output var logic powerdown_req, // power-down requested via pin
  output var logic irq_req, // internal interrupt request
  input wire logic link_up, // link status level
  input wire logic link_quality_good, // link quality level
  input wire logic energy_present, // energy detect level
  input wire logic speed_100, // resolved speed level
  input wire logic full_duplex, // duplex level
  input wire logic autoneg_done, // auto-negotiation complete level
  input wire logic false_carrier_evt, // false carrier pulse
  input wire logic rx_error_evt // receive error pulse
);
  // -------------------------------------------------------------
  // pin synchronisers and management clock edge
  // -------------------------------------------------------------
  logic mdc_s;
  logic mdio_s;
  logic pin_s;
  logic mdc_d;
  logic mdc_rise;

  // mdc idles low, mdio and the shared pin idle high
  peis_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h3)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({mdc, mdio_in, irq_pin_in}),
    .sync_out({mdc_s, mdio_s, pin_s})
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mdc_d <= 1'b0;
    end else begin
      mdc_d <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s && !mdc_d;

  // -------------------------------------------------------------
  // register state
  // -------------------------------------------------------------
  logic [3:0] ctrl;
  logic [NUM_EVT-1:0] evt_en;
  logic [NUM_EVT-1:0] evt_flag;
  logic [NUM_EVT-1:0] evt_hit;
  logic [CNT_W-1:0] fc_count;
  logic [CNT_W-1:0] rxe_count;
  logic fc_half;
  logic rxe_half;
  logic rd_stb;
  logic wr_stb;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] wr_data;
  logic clr_flags;
  logic clr_fc;
  logic clr_rxe;

  assign clr_flags = rd_stb && acc_addr == REG_EVT_ONE;
  assign clr_fc = rd_stb && acc_addr == REG_FC_CNT;
  assign clr_rxe = rd_stb && acc_addr == REG_RXE_CNT;

  // -------------------------------------------------------------
  // event counters
  // -------------------------------------------------------------
  peis_counter u_fc_cnt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .event_in(false_carrier_evt),
    .clear(clr_fc),
    .count(fc_count),
    .half_evt(fc_half)
  );

  peis_counter u_rxe_cnt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .event_in(rx_error_evt),
    .clear(clr_rxe),
    .count(rxe_count),
    .half_evt(rxe_half)
  );

  // -------------------------------------------------------------
  // change detection
  // -------------------------------------------------------------
  logic prev_lq;
  logic prev_energy;
  logic prev_link;
  logic prev_speed;
  logic prev_duplex;
  logic prev_aneg;

  // previous levels reset low, so a level already high at release
  // is reported once as a change (link quality only while link is up)
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_lq <= 1'b0;
      prev_energy <= 1'b0;
      prev_link <= 1'b0;
      prev_speed <= 1'b0;
      prev_duplex <= 1'b0;
      prev_aneg <= 1'b0;
    end else begin
      prev_lq <= link_quality_good;
      prev_energy <= energy_present;
      prev_link <= link_up;
      prev_speed <= speed_100;
      prev_duplex <= full_duplex;
      prev_aneg <= autoneg_done;
    end
  end

  always_comb begin
    evt_hit = '0;
    evt_hit[EVT_LQ] = (link_quality_good != prev_lq) && link_up;
    evt_hit[EVT_ENERGY] = energy_present != prev_energy;
    evt_hit[EVT_LINK] = link_up != prev_link;
    evt_hit[EVT_SPEED] = speed_100 != prev_speed;
    evt_hit[EVT_DUPLEX] = full_duplex != prev_duplex;
    evt_hit[EVT_ANEG] = autoneg_done && !prev_aneg;
    evt_hit[EVT_FC_HALF] = fc_half;
    evt_hit[EVT_RXE_HALF] = rxe_half;
  end

  // -------------------------------------------------------------
  // sticky flags: a new event beats the read that clears
  // -------------------------------------------------------------
  for (genvar i = 0; i < NUM_EVT; i++) begin : g_flag
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        evt_flag[i] <= FLAG_RESET[i];
      end else if (evt_hit[i]) begin
        evt_flag[i] <= 1'b1;
      end else if (clr_flags) begin
        evt_flag[i] <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_en <= EN_RESET;
    end else if (wr_stb && acc_addr == REG_EVT_ONE) begin
      evt_en <= wr_data[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTL_RESET;
    end else if (wr_stb && acc_addr == REG_IRQ_CTRL) begin
      ctrl <= wr_data[3:0];
    end
  end

  // -------------------------------------------------------------
  // interrupt and shared pin
  // -------------------------------------------------------------
  logic irq_now;
  logic [NUM_EVT-1:0] evt_armed;

  // each flag reaches the request only through its own enable bit
  assign evt_armed = evt_flag & evt_en;
  assign irq_now = (ctrl[CTL_GIE] && |evt_armed)
                   || ctrl[CTL_TEST]; // test bit forces a request

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= irq_now;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pin_oe <= 1'b0;
      irq_pin_out <= 1'b1;
    end else begin
      irq_pin_oe <= ctrl[CTL_OE];
      irq_pin_out <= ctrl[CTL_POL] ? !irq_now : irq_now;
    end
  end

  // pin reads as active-low power-down only while not driven
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      powerdown_req <= 1'b0;
    end else begin
      powerdown_req <= !ctrl[CTL_OE] && !pin_s;
    end
  end

  // -------------------------------------------------------------
  // read data selection
  // -------------------------------------------------------------
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] addr
  );
    logic [DATA_W-1:0] word;
    word = '0;
    case (addr)
      REG_IRQ_CTRL: word[3:0] = ctrl;
      REG_EVT_ONE: word = {evt_flag, evt_en};
      REG_FC_CNT: word[CNT_W-1:0] = fc_count;
      REG_RXE_CNT: word[CNT_W-1:0] = rxe_count;
      default: word = '0;
    endcase
    return word;
  endfunction : read_word

  // -------------------------------------------------------------
  // management frame engine, one step per mdc rising edge
  // -------------------------------------------------------------
  peis_state_e state;
  logic [5:0] pre_cnt;
  logic [4:0] bit_cnt;
  logic [11:0] hdr;
  logic [12:0] hdr_full;
  logic [DATA_W-1:0] shift;
  logic [DATA_W-1:0] next_shift_in;

  assign hdr_full = {hdr, mdio_s};
  assign next_shift_in = {shift[DATA_W-2:0], mdio_s};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      pre_cnt <= '0;
      bit_cnt <= '0;
      hdr <= '0;
      acc_addr <= '0;
    end else if (mdc_rise) begin
      case (state)
        ST_IDLE: begin
          if (mdio_s) begin
            if (pre_cnt != PREAMBLE_LEN) begin
              pre_cnt <= pre_cnt + 6'h01;
            end
          end else begin
            pre_cnt <= '0;
            if (pre_cnt == PREAMBLE_LEN) begin
              state <= ST_HDR;
              bit_cnt <= '0;
            end
          end
        end
        ST_HDR: begin
          hdr <= hdr_full[11:0];
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == HDR_LAST) begin
            acc_addr <= hdr_full[4:0];
            bit_cnt <= '0;
            // other station addresses and bad start bits are ignored
            if (!hdr_full[12] || hdr_full[9:5] != PHY_ADDR) begin
              state <= ST_IDLE;
            end else if (hdr_full[11:10] == OP_READ) begin
              state <= ST_RTA;
            end else if (hdr_full[11:10] == OP_WRITE) begin
              state <= ST_WR;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_RTA: begin
          state <= ST_RD;
          bit_cnt <= RD_BITS;
        end
        ST_RD: begin
          if (bit_cnt == '0) begin
            state <= ST_IDLE;
          end else begin
            bit_cnt <= bit_cnt - 5'h01;
          end
        end
        ST_WR: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == WR_BITS - 5'h01) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // data shifter, drive and access strobes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift <= '0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= '0;
    end else begin
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      if (mdc_rise) begin
        case (state)
          ST_RTA: begin
            // snapshot taken here; rd_stb clears the register one cycle later
            shift <= read_word(acc_addr);
            rd_stb <= 1'b1;
            mdio_oe <= 1'b1;
            mdio_out <= 1'b0;
          end
          ST_RD: begin
            if (bit_cnt == '0) begin
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
            end else begin
              mdio_out <= shift[DATA_W-1];
              shift <= {shift[DATA_W-2:0], 1'b0};
            end
          end
          ST_WR: begin
            shift <= next_shift_in;
            if (bit_cnt == WR_BITS - 5'h01) begin
              wr_data <= next_shift_in;
              wr_stb <= 1'b1;
            end
          end
          default: begin
            mdio_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule : peis_top
`default_nettype wire

//--- bench/peis_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module peis_chk (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic mdc, // management clock
  input wire logic mdio_out, // management data value
  input wire logic mdio_oe, // management data enable
  input wire logic irq_pin_in, // shared pin level
  input wire logic irq_pin_out, // shared pin value
  input wire logic irq_pin_oe, // shared pin enable
  input wire logic powerdown_req, // power-down request
  input wire logic irq_req, // interrupt request
  input wire logic link_up, // link level
  input wire logic link_quality_good, // quality level
  input wire logic energy_present, // energy level
  input wire logic speed_100, // speed level
  input wire logic full_duplex, // duplex level
  input wire logic autoneg_done, // autoneg level
  input wire logic false_carrier_evt, // counter pulse
  input wire logic rx_error_evt // counter pulse
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [7:0] oe_cnt;
  logic [7:0] idle_cnt;
  logic [7:0] ev_age;
  logic [5:0] lv_q;
  wire logic [5:0] lv = {link_quality_good, energy_present, link_up,
    speed_100, full_duplex, autoneg_done};
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_cnt <= 8'h00;
      idle_cnt <= 8'h00;
      ev_age <= 8'h00;
      lv_q <= 6'h00;
    end else begin
      oe_cnt <= mdio_oe ? oe_cnt + 8'h01 : 8'h00;
      idle_cnt <= mdc ? 8'h00 : idle_cnt + {7'h00, idle_cnt != 8'hFF};
      lv_q <= lv;
      if (lv != lv_q || false_carrier_evt || rx_error_evt) begin
        ev_age <= 8'h00;
      end else begin
        ev_age <= ev_age + {7'h00, ev_age != 8'hFF};
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  rst_vals_a: assert property (
    $rose(reset_n) |-> irq_pin_out && !irq_req && !mdio_oe)
    else $error("outputs wrong after reset");
  oe_span_a: assert property (
    $fell(mdio_oe) |-> oe_cnt inside {[135:137]})
    else $error("read drive span wrong");
  ta_zero_a: assert property (
    $rose(mdio_oe) |-> !mdio_out) else $error("turnaround not low");
  bit_step_a: assert property (
    mdio_oe && $past(mdio_oe) && $changed(mdio_out) |-> mdc || $past(mdc))
    else $error("read bit changed off clock");
  idle_quiet_a: assert property (
    idle_cnt > 8'd20 |-> !mdio_oe) else $error("drive while idle");
  irq_clear_a: assert property (
    $fell(irq_req) |-> idle_cnt < 8'd12) else $error("flag lost unread");
  irq_cause_a: assert property (
    $rose(irq_req) |-> ev_age < 8'd6 || idle_cnt < 8'd12)
    else $error("interrupt without cause");
  pin_follow_a: assert property (
    $rose(irq_req) && irq_pin_oe |-> ##[0:1] $changed(irq_pin_out))
    else $error("pin did not follow interrupt");
  pd_excl_a: assert property (
    irq_pin_oe && $past(irq_pin_oe) |-> !powerdown_req)
    else $error("power-down while pin driven");
  pd_input_a: assert property (
    (!irq_pin_oe && !irq_pin_in) [*5] |-> powerdown_req)
    else $error("power-down not seen");
  pd_quiet_a: assert property (
    $rose(reset_n) && irq_pin_in |-> ##1 !powerdown_req ##1 !powerdown_req)
    else $error("false power-down after reset");
  read_c: cover property ($fell(mdio_oe));
  irq_c: cover property ($rose(irq_req));
  pd_c: cover property ($rose(powerdown_req));
endmodule : peis_chk
`default_nettype wire

//--- bench/peis_mgmt_host.sv
`timescale 1ns/100ps
`default_nettype none
module peis_mgmt_host
  import peis_pkg::*;
#(
  parameter logic [4:0] PHY = 5'h05
) (
  input wire logic core_clk, // system clock
  input wire logic mdio_out, // device data value
  input wire logic mdio_oe, // device drive enable
  output var logic mdc, // management clock, still when idle
  output var logic mdio_in // resolved line level
);
  logic drv;
  logic bit_v;
  // line has a pull-up, so released means high
  assign mdio_in = mdio_oe ? mdio_out : (drv ? bit_v : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    bit_v = 1'b1;
  end
  task automatic frame(input logic [1:0] op, input logic [4:0] ra,
      input logic [15:0] wd, output logic [16:0] rd);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'b01, op, PHY, ra, 2'b10, wd};
    rd = 17'h00000;
    @(posedge core_clk);
    for (int i = 0; i < 64; i++) begin
      mdc <= 1'b0;
      drv <= !(op == OP_READ && i >= 46);
      bit_v <= f[63-i];
      repeat (4) @(posedge core_clk);
      mdc <= 1'b1;
      if (i >= 47) rd = {rd[15:0], mdio_in};
      repeat (4) @(posedge core_clk);
    end
    mdc <= 1'b0;
    drv <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : frame
endmodule : peis_mgmt_host
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import peis_pkg::*;
  logic core_clk, reset_n, irq_pin_in, pd_level, fc_evt, rx_evt;
  logic mdc, mdio_in, mdio_out, mdio_oe, irq_pin_out, irq_pin_oe;
  logic powerdown_req, irq_req;
  logic [7:0] lv;
  logic [16:0] v;
  int n_errors;
  int checks;
  int evs[6] = '{5, 7, 6, 4, 3, 2};
  assign irq_pin_in = irq_pin_oe ? irq_pin_out : pd_level;
  peis_top #(.PHY_ADDR(5'h05)) dut (.core_clk(core_clk),
    .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq_pin_in(irq_pin_in),
    .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
    .powerdown_req(powerdown_req), .irq_req(irq_req),
    .link_up(lv[5]), .link_quality_good(lv[7]),
    .energy_present(lv[6]), .speed_100(lv[4]), .full_duplex(lv[3]),
    .autoneg_done(lv[2]), .false_carrier_evt(fc_evt),
    .rx_error_evt(rx_evt));
  peis_mgmt_host #(.PHY(5'h05)) host (.core_clk(core_clk),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_in(mdio_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    host.frame(OP_READ, ra, 16'h0000, v);
    check(v, {1'b0, exp});
  endtask : rd_chk
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    host.frame(OP_WRITE, ra, d, v);
  endtask : wr
  task automatic toggle(input int e);
    @(posedge core_clk);
    lv[e] <= ~lv[e];
    repeat (4) @(posedge core_clk);
  endtask : toggle
  task automatic pulses(input int n, input bit rx);
    repeat (n) begin
      @(posedge core_clk);
      if (rx) rx_evt <= 1'b1;
      else fc_evt <= 1'b1;
      @(posedge core_clk);
      rx_evt <= 1'b0;
      fc_evt <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
  endtask : pulses
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(REG_EVT_ONE, 16'h0000);
    rd_chk(REG_IRQ_CTRL, 16'h0008);
    rd_chk(5'h1F, 16'h0000);
    wr(REG_EVT_ONE, 16'hFFFF);
    rd_chk(REG_EVT_ONE, 16'h00FF);
    wr(REG_IRQ_CTRL, 16'h000B);
  endtask : t_reset
  task automatic t_event(input int e);
    toggle(e);
    check({16'h0000, irq_req}, 17'h00001);
    check({16'h0000, irq_pin_out}, 17'h00000);
    rd_chk(REG_EVT_ONE, 16'h00FF | (16'h0100 << e));
    check({16'h0000, irq_req}, 17'h00000);
  endtask : t_event
  task automatic t_count();
    pulses(128, 1'b0);
    rd_chk(REG_EVT_ONE, 16'h02FF);
    rd_chk(REG_FC_CNT, 16'h0080);
    rd_chk(REG_FC_CNT, 16'h0000);
    pulses(300, 1'b1);
    rd_chk(REG_RXE_CNT, 16'h00FF);
    rd_chk(REG_EVT_ONE, 16'h01FF);
  endtask : t_count
  task automatic t_mask();
    wr(REG_EVT_ONE, 16'h007F);
    toggle(7);
    check({16'h0000, irq_req}, 17'h00000);
    rd_chk(REG_EVT_ONE, 16'h807F);
    wr(REG_EVT_ONE, 16'h00FF);
    wr(REG_IRQ_CTRL, 16'h0009);
    toggle(6);
    check({16'h0000, irq_req}, 17'h00000);
    rd_chk(REG_EVT_ONE, 16'h40FF);
    toggle(5);
    toggle(7);
    rd_chk(REG_EVT_ONE, 16'h20FF);
  endtask : t_mask
  task automatic t_pin();
    wr(REG_IRQ_CTRL, 16'h0008);
    check({16'h0000, irq_pin_oe}, 17'h00000);
    @(posedge core_clk);
    pd_level <= 1'b0;
    repeat (8) @(posedge core_clk);
    check({16'h0000, powerdown_req}, 17'h00001);
    pd_level <= 1'b1;
    wr(REG_IRQ_CTRL, 16'h0003);
    check({16'h0000, irq_pin_out}, 17'h00000);
    wr(REG_IRQ_CTRL, 16'h0007);
    check({16'h0000, irq_req}, 17'h00001);
    check({16'h0000, irq_pin_out}, 17'h00001);
  endtask : t_pin
  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
  initial begin
    n_errors = 0;
    checks = 0;
    reset_n = 1'b0;
    pd_level = 1'b1;
    fc_evt = 1'b0;
    rx_evt = 1'b0;
    lv = 8'h00;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    foreach (evs[i]) t_event(evs[i]);
    t_count();
    t_mask();
    t_pin();
    complete_run();
  end
endmodule : tb
bind peis_top peis_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .irq_pin_in(irq_pin_in), .irq_pin_out(irq_pin_out),
  .irq_pin_oe(irq_pin_oe), .powerdown_req(powerdown_req),
  .irq_req(irq_req), .link_up(link_up),
  .link_quality_good(link_quality_good),
  .energy_present(energy_present), .speed_100(speed_100),
  .full_duplex(full_duplex), .autoneg_done(autoneg_done),
  .false_carrier_evt(false_carrier_evt), .rx_error_evt(rx_error_evt));
`default_nettype wire
